/* File: logic/uart_flow_break_reset.v */
// Overview of operation
// - characters enter on the receive line and leave on the transmit line
// - clear-to-send and request-to-send are asserted when low
// - 8 data bits, parity none/odd/even, 1 or 2 stops, 1200 to 4M baud
// - break is the receive line held continuously low
// - break longer than the timeout item resets the device
// - device can drive a break on the transmit line to wake the host
// - baud rate is the reference clock divided by the divider item
// - request-to-send driven low when ready to accept characters
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`include "uart_consts.vh"
module uart_flow_break_reset (
  input  wire        ref_clk_i,
  input  wire        rst_n_i,
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  output reg         irq_o,
  input  wire        rx_i,
  output reg         tx_o,
  input  wire        cts_n_i,
  output reg         rts_n_o,
  output reg         brk_reset_o
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_START = 3'd1;
  localparam [2:0] ST_DATA  = 3'd2;
  localparam [2:0] ST_PAR   = 3'd3;
  localparam [2:0] ST_STOP  = 3'd4;

  reg  [5:0]  ctrl_r;
  reg  [19:0] baud_div_r;
  reg  [31:0] brk_timeout_r;
  reg  [4:0]  irq_st_r;
  reg  [4:0]  irq_mask_r;
  wire        rx_s2_r;
  wire        cts_s2_r;
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // both lines idle high, so reset to one gives no false start
  sync_2ff #(
    .RST_VAL (1'b1)
  ) u_rx_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .d_i       (rx_i),
    .q_o       (rx_s2_r)
  );
  sync_2ff #(
    .RST_VAL (1'b1)
  ) u_cts_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .d_i       (cts_n_i),
    .q_o       (cts_s2_r)
  );
  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  // divider counts the fixed 100 MHz clock, so the rate is set in
  // reference cycles only
  reg  [2:0]  tx_st_r;
  reg  [19:0] tx_cnt_r;
  reg  [2:0]  tx_bit_r;
  reg  [7:0]  tx_sh_r;
  reg         tx_par_r;
  reg         tx_stop2_r;
  reg  [7:0]  tx_hold_r;
  reg         tx_full_r;
  reg         tx_done_r;
  wire        tx_tick = (tx_cnt_r == 20'h00000);
  wire        tx_load = wr_i && (addr_i == `REG_TX_DATA);
  wire        cts_ok  = !ctrl_r[`CTRL_FLOW_EN] || !cts_s2_r;
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_st_r    <= ST_IDLE;
      tx_cnt_r   <= 20'h00000;
      tx_done_r  <= 1'b0;
      tx_bit_r   <= 3'h0;
      tx_sh_r    <= 8'h00;
      tx_par_r   <= 1'b0;
      tx_stop2_r <= 1'b0;
      tx_hold_r  <= 8'h00;
      tx_full_r  <= 1'b0;
      tx_o       <= 1'b1;
    end else begin
      tx_done_r <= 1'b0;
      if (tx_load) begin
        tx_hold_r <= wdata_i[7:0];
        tx_full_r <= 1'b1;
      end
      tx_cnt_r <= tx_tick ? baud_div_r - 20'h00001 :
                            tx_cnt_r - 20'h00001;
      case (tx_st_r)
        ST_IDLE: begin
          tx_cnt_r <= baud_div_r - 20'h00001;
          if (ctrl_r[`CTRL_SEND_BRK]) begin
            tx_o <= 1'b0;
          end else if (tx_full_r && cts_ok) begin
            tx_o      <= 1'b0;
            tx_sh_r   <= tx_hold_r;
            tx_par_r  <= ^tx_hold_r ^ ctrl_r[`CTRL_PAR_ODD];
            tx_full_r <= tx_load;
            tx_bit_r  <= 3'h0;
            tx_st_r   <= ST_START;
          end else begin
            tx_o <= 1'b1;
          end
        end
        ST_START: if (tx_tick) begin
          tx_o    <= tx_sh_r[0];
          tx_st_r <= ST_DATA;
        end
        ST_DATA: if (tx_tick) begin
          tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
          tx_bit_r <= tx_bit_r + 3'h1;
          if (tx_bit_r == 3'h7) begin
            tx_o       <= ctrl_r[`CTRL_PAR_EN] ? tx_par_r : 1'b1;
            tx_st_r    <= ctrl_r[`CTRL_PAR_EN] ? ST_PAR : ST_STOP;
            tx_stop2_r <= ctrl_r[`CTRL_STOP2];
          end else begin
            tx_o <= tx_sh_r[1];
          end
        end
        ST_PAR: if (tx_tick) begin
          tx_o    <= 1'b1;
          tx_st_r <= ST_STOP;
        end
        ST_STOP: if (tx_tick) begin
          if (tx_stop2_r) begin
            tx_stop2_r <= 1'b0;
          end else begin
            tx_done_r <= 1'b1;
            tx_st_r <= ST_IDLE;
          end
        end
        default: tx_st_r <= ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // receiver
  // ----------------------------------------
  reg  [2:0]  rx_st_r;
  reg  [19:0] rx_cnt_r;
  reg  [2:0]  rx_bit_r;
  reg  [7:0]  rx_sh_r;
  reg  [7:0]  rx_data_r;
  reg         rx_full_r;
  reg         rx_stop2_r;
  reg  [31:0] brk_cnt_r;
  reg         rx_done_r;
  reg         par_err_r;
  reg         frame_err_r;
  reg         brk_det_r;
  // break flagged after twelve bit times, longer than any legal frame
  wire [31:0] brk_det_lim = {12'h000, baud_div_r} * 32'h0000000c;
  wire        rx_tick = (rx_cnt_r == 20'h00000);
  wire        rx_take = rd_i && (addr_i == `REG_RX_DATA);
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_st_r    <= ST_IDLE;
      rx_cnt_r   <= 20'h00000;
      rx_done_r  <= 1'b0;
      par_err_r  <= 1'b0;
      frame_err_r <= 1'b0;
      brk_det_r  <= 1'b0;
      rx_bit_r   <= 3'h0;
      rx_sh_r    <= 8'h00;
      rx_data_r  <= 8'h00;
      rx_full_r  <= 1'b0;
      rx_stop2_r <= 1'b0;
      brk_cnt_r  <= 32'h00000000;
    end else begin
      rx_done_r   <= 1'b0;
      par_err_r   <= 1'b0;
      frame_err_r <= 1'b0;
      brk_det_r   <= 1'b0;
      if (rx_take)
        rx_full_r <= 1'b0;
      // break: low held without interruption
      if (rx_s2_r) begin
        brk_cnt_r <= 32'h00000000;
      end else if (brk_cnt_r != 32'hffffffff) begin
        brk_cnt_r <= brk_cnt_r + 32'h00000001;
        if (brk_cnt_r == brk_det_lim)
          brk_det_r <= 1'b1;
      end
      rx_cnt_r <= rx_tick ? baud_div_r - 20'h00001 :
                            rx_cnt_r - 20'h00001;
      case (rx_st_r)
        ST_IDLE: if (!rx_s2_r) begin
          // half-bit wait centres the samples
          rx_cnt_r <= {1'b0, baud_div_r[19:1]};
          rx_st_r  <= ST_START;
        end
        ST_START: if (rx_tick) begin
          rx_bit_r <= 3'h0;
          rx_st_r  <= rx_s2_r ? ST_IDLE : ST_DATA;
        end
        ST_DATA: if (rx_tick) begin
          rx_sh_r  <= {rx_s2_r, rx_sh_r[7:1]};
          rx_bit_r <= rx_bit_r + 3'h1;
          if (rx_bit_r == 3'h7) begin
            rx_st_r    <= ctrl_r[`CTRL_PAR_EN] ? ST_PAR : ST_STOP;
            rx_stop2_r <= ctrl_r[`CTRL_STOP2];
          end
        end
        ST_PAR: if (rx_tick) begin
          if ((^rx_sh_r ^ ctrl_r[`CTRL_PAR_ODD]) != rx_s2_r)
            par_err_r <= 1'b1;
          rx_st_r <= ST_STOP;
        end
        ST_STOP: if (rx_tick) begin
          if (!rx_s2_r) begin
            frame_err_r <= 1'b1;
            rx_st_r <= ST_IDLE;
          end else if (rx_stop2_r) begin
            rx_stop2_r <= 1'b0;
          end else begin
            rx_data_r <= rx_sh_r;
            rx_full_r <= 1'b1;
            rx_done_r <= 1'b1;
            rx_st_r   <= ST_IDLE;
          end
        end
        default: rx_st_r <= ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // registers, interrupts, reset request
  // ----------------------------------------
  // event pulses are flops, so status sets one cycle after the event
  wire [4:0]  ev = {brk_det_r, frame_err_r, par_err_r,
                    tx_done_r, rx_done_r};
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r        <= `CTRL_RST;
      baud_div_r    <= `BAUD_DIV_RST;
      brk_timeout_r <= `BRK_TIMEOUT_RST;
      irq_st_r      <= 5'h00;
      irq_mask_r    <= 5'h00;
      rdata_o       <= 32'h00000000;
      irq_o         <= 1'b0;
      rts_n_o       <= 1'b1;
      brk_reset_o   <= 1'b0;
    end else begin
      if (wr_i) begin
        case (addr_i)
          `REG_CTRL:        ctrl_r <= wdata_i[5:0];
          `REG_BAUD_DIV:    baud_div_r <= (wdata_i[19:0] < 20'h00019) ?
                                          20'h00019 : wdata_i[19:0];
          `REG_BRK_TIMEOUT: brk_timeout_r <= wdata_i;
          `REG_IRQ_MASK:    irq_mask_r <= wdata_i[4:0];
          default: ;
        endcase
      end
      // set wins over write-one-to-clear
      irq_st_r <= (irq_st_r & ~((wr_i && addr_i == `REG_IRQ_STATUS) ?
                  wdata_i[4:0] : 5'h00)) | ev;
      irq_o    <= |(irq_st_r & irq_mask_r);
      // ready only with room in the receive holding register
      rts_n_o  <= !(ctrl_r[`CTRL_RX_READY] && !rx_full_r);
      brk_reset_o <= !rx_s2_r && (brk_cnt_r > brk_timeout_r);
      rdata_o <= 32'h00000000;
      if (rd_i) begin
        case (addr_i)
          `REG_CTRL:        rdata_o <= {26'h0, ctrl_r};
          `REG_BAUD_DIV:    rdata_o <= {12'h000, baud_div_r};
          `REG_BRK_TIMEOUT: rdata_o <= brk_timeout_r;
          `REG_RX_DATA:     rdata_o <= {24'h0, rx_data_r};
          `REG_STATUS:      rdata_o <= {26'h0, !rx_s2_r, cts_s2_r,
                                        tx_full_r, tx_st_r != ST_IDLE,
                                        rx_full_r, 1'b0};
          `REG_IRQ_STATUS:  rdata_o <= {27'h0, irq_st_r};
          `REG_IRQ_MASK:    rdata_o <= {27'h0, irq_mask_r};
          default:          rdata_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // uart_flow_break_reset

// ----------------------------------------
// two-flop synchroniser
// ----------------------------------------
module sync_2ff #(
  parameter [0:0] RST_VAL = 1'b1
) (
  input  wire ref_clk_i,
  input  wire rst_n_i,
  input  wire d_i,
  output reg  q_o
);
  reg meta_r;
  // only q_o is read outside; meta_r may still be settling
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= RST_VAL;
      q_o    <= RST_VAL;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule // sync_2ff

/* File: logic/uart_consts.vh */
`ifndef UART_CONSTS_VH
`define UART_CONSTS_VH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define REG_CTRL        8'h00
`define REG_BAUD_DIV    8'h04
`define REG_BRK_TIMEOUT 8'h08
`define REG_TX_DATA     8'h0c
`define REG_RX_DATA     8'h10
`define REG_STATUS      8'h14
`define REG_IRQ_STATUS  8'h18
`define REG_IRQ_MASK    8'h1c
// ----------------------------------------
// control fields
// ----------------------------------------
`define CTRL_PAR_EN     0
`define CTRL_PAR_ODD    1
`define CTRL_STOP2      2
`define CTRL_FLOW_EN    3
`define CTRL_SEND_BRK   4
`define CTRL_RX_READY   5
// ----------------------------------------
// interrupt bits
// ----------------------------------------
`define IRQ_RX_DONE     0
`define IRQ_TX_DONE     1
`define IRQ_PAR_ERR     2
`define IRQ_FRAME_ERR   3
`define IRQ_BRK_DET     4
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define CTRL_RST        6'h20
`define REF_CLK_HZ      100000000
`define BAUD_RST_HZ     115200
`define BAUD_DIV_RST    20'h00364
`define BRK_TIMEOUT_RST 32'h000f4240
`define DATA_BITS       8
`endif

/* File: test/link_chk_chk.sv */
`timescale 1ns/10ps
`include "uart_consts.vh"
module link_chk (
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        irq_o,
  input wire logic        rx_i,
  input wire logic        tx_o,
  input wire logic        cts_n_i,
  input wire logic        rts_n_o,
  input wire logic        brk_reset_o
);
  logic        flow_r;
  logic        sbrk_r;
  logic [31:0] div_r;
  logic [31:0] tmo_r;
  logic [31:0] lo_r;
  logic [31:0] hi_r;
  logic [31:0] cts_r;
  wire         wc = wr_i && addr_i == `REG_CTRL;
  // shadow of config writes; counts wrap only past any run we make
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flow_r <= 1'b0;
      sbrk_r <= 1'b0;
      div_r <= `BAUD_DIV_RST;
      tmo_r <= `BRK_TIMEOUT_RST;
      lo_r <= 32'h0;
      hi_r <= 32'h0;
      cts_r <= 32'h0;
    end else begin
      if (wc) flow_r <= wdata_i[`CTRL_FLOW_EN];
      if (wc) sbrk_r <= wdata_i[`CTRL_SEND_BRK];
      if (wr_i && addr_i == `REG_BAUD_DIV)
        div_r <= (wdata_i[19:0] < 20'h00019) ? 32'h19 :
                 {12'h000, wdata_i[19:0]};
      if (wr_i && addr_i == `REG_BRK_TIMEOUT) tmo_r <= wdata_i;
      lo_r <= rx_i ? 32'h0 : lo_r + 32'h1;
      hi_r <= tx_o ? hi_r + 32'h1 : 32'h0;
      cts_r <= cts_n_i ? cts_r + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_brk_on;
    $rose(sbrk_r);
  endsequence
  // a fall after a long high run is a new start, not a data bit
  sequence s_new_start;
    flow_r && !sbrk_r && $fell(tx_o) && hi_r > 9 * div_r;
  endsequence
  AST_RD_IDLE: assert property (
    !$past(rd_i) |-> rdata_o == 32'h0) else $error("rdata not idle");
  AST_RTS_OFF: assert property (
    wc && !wdata_i[`CTRL_RX_READY] |=> ##[0:2] rts_n_o)
    else $error("rts low while not ready");
  AST_BRK_LOW: assert property (
    brk_reset_o |-> !$past(rx_i, 6)) else $error("break without low rx");
  AST_BRK_EARLY: assert property (
    $rose(brk_reset_o) |-> lo_r > tmo_r) else $error("break reset early");
  AST_BRK_LATE: assert property (
    lo_r == tmo_r + 32'h8 |-> brk_reset_o) else $error("break reset late");
  AST_BRK_END: assert property (
    $rose(rx_i) |-> ##[1:6] !brk_reset_o) else $error("break reset stuck");
  AST_BRK_SEND: assert property (
    s_brk_on |-> ##[1:400] !tx_o) else $error("no break on tx");
  AST_CTS_HOLD: assert property (
    s_new_start |-> cts_r < 32'h8) else $error("start while cts high");
endmodule // link_chk
bind uart_flow_break_reset link_chk u_chk (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .irq_o(irq_o), .rx_i(rx_i), .tx_o(tx_o), .cts_n_i(cts_n_i),
  .rts_n_o(rts_n_o), .brk_reset_o(brk_reset_o));

/* File: test/host_model.sv */
`timescale 1ns/10ps
module host_model (
  input  wire logic ref_clk_i,
  input  wire logic tx_i,
  output logic      rx_o,
  output logic      cts_n_o
);
  int div = 25;
  initial begin
    rx_o = 1'b1;
    cts_n_o = 1'b0;
  end
  task automatic cts(input logic v);
    cts_n_o <= v;
  endtask
  task automatic line(input logic v, input int n);
    rx_o <= v;
    repeat (n) @(posedge ref_clk_i);
  endtask
  // bad flips parity to provoke an error
  task automatic send(input logic [7:0] d, input logic pe, po, bad);
    logic [10:0] f;
    f = {1'b1, ^d ^ po ^ bad, d, 1'b0};
    for (int i = 0; i < 11; i++)
      if (pe || i != 9) line(f[i], div);
    line(1'b1, div);
  endtask
  // bits sampled mid-cell from the start edge; st is the first low run
  task automatic get(output logic [10:0] f, output int st);
    int k;
    for (int n = 0; n < 3000 && tx_i; n++) @(posedge ref_clk_i);
    st = 0;
    for (k = 0; k < 11 * div; k++) begin
      if (k % div == div / 2) f[k / div] = tx_i;
      if (st == k && !tx_i) st++;
      @(posedge ref_clk_i);
    end
  endtask
endmodule // host_model

/* File: test/tb_uart_flow_break_reset.sv */
`timescale 1ns/10ps
`include "uart_consts.vh"
module tb_uart_flow_break_reset;
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [31:0] rdata_o, d;
  logic        irq_o, rx_i, tx_o, cts_n_i, rts_n_o, brk_reset_o;
  logic [10:0] f;
  int          fails = 0;
  int          n_checks = 0;
  int          st;
  always #5 ref_clk_i = ~ref_clk_i;
  uart_flow_break_reset DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .irq_o(irq_o), .rx_i(rx_i), .tx_o(tx_o),
    .cts_n_i(cts_n_i), .rts_n_o(rts_n_o), .brk_reset_o(brk_reset_o));
  host_model u_host (.ref_clk_i(ref_clk_i), .tx_i(tx_o), .rx_o(rx_i),
    .cts_n_o(cts_n_i));
  task chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task wait2;
    repeat (3) @(posedge ref_clk_i);
  endtask
  task t_reset;
    chk("rts", 32'(rts_n_o), 32'h0);
    rd(`REG_CTRL, d);
    chk("ctrl", d, 32'(`CTRL_RST));
    rd(`REG_BAUD_DIV, d);
    chk("div", d, 32'd868);
    wr(`REG_BAUD_DIV, 32'h5);
    rd(`REG_BAUD_DIV, d);
    chk("div clamp", d, 32'h19);
  endtask
  task t_tx;
    wr(`REG_CTRL, 32'h27);
    wr(`REG_TX_DATA, 32'ha5);
    u_host.get(f, st);
    chk("tx frame", 32'(f), 32'({2'b11, 8'ha5, 1'b0}));
    chk("bit time", st, 32'h19);
  endtask
  task t_rx;
    wr(`REG_CTRL, 32'h21);
    wr(`REG_IRQ_MASK, 32'h05);
    u_host.send(8'h3c, 1'b1, 1'b0, 1'b0);
    rd(`REG_IRQ_STATUS, d);
    chk("irq st", d, 32'h3);
    chk("irq on", 32'(irq_o), 32'h1);
    rd(`REG_RX_DATA, d);
    chk("rx data", d, 32'h3c);
    wr(`REG_IRQ_STATUS, 32'h3);
    wait2;
    chk("irq clr", 32'(irq_o), 32'h0);
    u_host.send(8'hc3, 1'b1, 1'b0, 1'b1);
    rd(`REG_IRQ_STATUS, d);
    chk("par err", d & 32'h4, 32'h4);
    wr(`REG_IRQ_MASK, 32'h0);
    wait2;
    chk("irq mask", 32'(irq_o), 32'h0);
    rd(8'h20, d);
    chk("unmapped", d, 32'h0);
    chk("rts full", 32'(rts_n_o), 32'h1);
  endtask
  task t_flow;
    wr(`REG_CTRL, 32'h28);
    u_host.cts(1'b1);
    wr(`REG_TX_DATA, 32'h5a);
    repeat (300) @(posedge ref_clk_i);
    chk("held", 32'(tx_o), 32'h1);
    rd(`REG_STATUS, d);
    chk("status", d, 32'h1a);
    u_host.cts(1'b0);
    u_host.get(f, st);
    chk("flow frame", 32'(f), 32'({2'b11, 8'h5a, 1'b0}));
    rd(`REG_RX_DATA, d);
    chk("rx ovr", d, 32'hc3);
    wait2;
    chk("rts on", 32'(rts_n_o), 32'h0);
    wr(`REG_CTRL, 32'h08);
    wait2;
    chk("rts off", 32'(rts_n_o), 32'h1);
  endtask
  task t_brk;
    wr(`REG_CTRL, 32'h30);
    wait2;
    chk("brk tx", 32'(tx_o), 32'h0);
    wr(`REG_CTRL, 32'h20);
    wr(`REG_BRK_TIMEOUT, 32'h32);
    u_host.line(1'b0, 40);
    chk("short brk", 32'(brk_reset_o), 32'h0);
    u_host.line(1'b1, 4);
    u_host.line(1'b0, 70);
    chk("long brk", 32'(brk_reset_o), 32'h1);
    u_host.line(1'b0, 260);
    rd(`REG_IRQ_STATUS, d);
    chk("brk det", d & 32'h10, 32'h10);
    u_host.line(1'b1, 8);
    chk("brk end", 32'(brk_reset_o), 32'h0);
  endtask
  task finish_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    fails++;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    #1;
    t_reset;
    t_tx;
    t_rx;
    t_flow;
    t_brk;
    finish_test;
  end
endmodule // tb_uart_flow_break_reset
